/* verilog/tiosel_dev.sv */
// Timer I/O mode select registers for channels 4 to 11
// Operation
// [RULE1] Upper field of first register: pair 6/7
// [RULE2] Lower field of first register: pair 4/5
// [RULE3] Upper field of second register: pair 10/11
// [RULE4] Lower field of second register: pair 8/9
// [RULE5] Codes 0 to 7 select modes 0-7
// [RULE6] Code 8 is mode 8; others prohibited
// [RULE7] Rewrite only while timer function is reset
// [RULE8] Pair 8/9 full mode: no channel 9 trigger
// [RULE9] Unused channel 9 trigger: edge select 00
// [RULE10] All fields reset to zero, mode 0
// [RULE11] Sharing pair takes cascade from pair below
`timescale 1ns/10ps
module tiosel_dev (
  // Clock and reset
  input  wire logic       clk_i,
  input  wire logic       rst_i,
  // Link to the controller
  tiosel_if.device        lnk,
  // Channel triggers and cascade
  input  wire logic       cascade_in_i,
  input  wire logic [3:0] pair_trig_i,
  output logic [3:0]      pair_trig_o,
  output logic            cascade_out_o,
  // Decoded modes
  output logic [3:0]      pair_four_five_mode_o,
  output logic [3:0]      pair_six_seven_mode_o,
  output logic [3:0]      pair_eight_nine_mode_o,
  output logic [3:0]      pair_ten_eleven_mode_o
);
  typedef struct packed {
    logic [15:0] sel_a;
    logic [15:0] sel_b;
    logic        refused;
    logic        bad;
    logic        conflict;
  } tiosel_dev_t;
  tiosel_dev_t r;
  tiosel_dev_t next_r;
  logic [4:0]  casc;

  function automatic logic code_ok(input logic [3:0] c);
    code_ok = (c <= tiosel_pkg::MODE_MAX); // [RULE5] [RULE6]
  endfunction

  function automatic logic [3:0] fld(input logic [15:0] v, input int lsb);
    fld = v[lsb +: tiosel_pkg::FIELD_W];
  endfunction

  always_comb begin
    next_r         = r;
    next_r.refused = 1'b0;
    if (lnk.sel_we) begin
      if (lnk.timer_function_select != tiosel_pkg::FUNC_SEL_RESET) begin
        next_r.refused = 1'b1; // [RULE7]
      end else if (!code_ok(fld(lnk.sel_wdata, tiosel_pkg::HI_FIELD_LSB)) ||
                   !code_ok(fld(lnk.sel_wdata, tiosel_pkg::LO_FIELD_LSB))) begin
        next_r.refused = 1'b1; // [RULE6]
      end else if (lnk.sel_addr) begin
        next_r.sel_b = {lnk.sel_wdata[15:8], 8'h00}; // [RULE3] [RULE4]
      end else begin
        next_r.sel_a = {lnk.sel_wdata[15:8], 8'h00}; // [RULE1] [RULE2]
      end
    end
    next_r.bad = !code_ok(fld(next_r.sel_a, tiosel_pkg::HI_FIELD_LSB)) ||
                 !code_ok(fld(next_r.sel_a, tiosel_pkg::LO_FIELD_LSB)) ||
                 !code_ok(fld(next_r.sel_b, tiosel_pkg::HI_FIELD_LSB)) ||
                 !code_ok(fld(next_r.sel_b, tiosel_pkg::LO_FIELD_LSB));
    next_r.conflict = (fld(next_r.sel_b, tiosel_pkg::LO_FIELD_LSB) ==
                       tiosel_pkg::TIOSEL_MODE_FULL) &&
                      (lnk.trigger_edge_select_ch9 != tiosel_pkg::EGS_UNUSED); // [RULE8] [RULE9]
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      r.sel_a    <= tiosel_pkg::SEL_RESET; // [RULE10]
      r.sel_b    <= tiosel_pkg::SEL_RESET; // [RULE10]
      r.refused  <= 1'b0;
      r.bad      <= 1'b0;
      r.conflict <= 1'b0;
    end else begin
      r <= next_r;
    end
  end

  // Cascade chain across pairs 4/5 to 10/11
  assign casc[0] = cascade_in_i;
  for (genvar i = 0; i < tiosel_pkg::NUM_PAIRS; i++) begin : g_pair
    logic [3:0] m;
    assign m = (i < 2) ? fld(r.sel_a, (i == 0) ? tiosel_pkg::LO_FIELD_LSB :
                                                 tiosel_pkg::HI_FIELD_LSB)
                       : fld(r.sel_b, (i == 2) ? tiosel_pkg::LO_FIELD_LSB :
                                                 tiosel_pkg::HI_FIELD_LSB);
    tiosel_route u_route (
      .clk_i         (clk_i),
      .rst_i         (rst_i),
      .mode_i        (m),
      .cascade_in_i  (casc[i]),
      .own_trig_i    (pair_trig_i[i]),
      .trig_o        (pair_trig_o[i]),
      .cascade_out_o (casc[i+1])
    ); // [RULE11]
  end
  assign cascade_out_o = casc[4];

  assign lnk.sel_rdata_a         = r.sel_a;
  assign lnk.sel_rdata_b         = r.sel_b;
  assign lnk.write_refused       = r.refused;
  assign lnk.bad_code            = r.bad;
  assign lnk.full_trig_conflict  = r.conflict;
  assign pair_four_five_mode_o   = r.sel_a[11:8];
  assign pair_six_seven_mode_o   = r.sel_a[15:12];
  assign pair_eight_nine_mode_o  = r.sel_b[11:8];
  assign pair_ten_eleven_mode_o  = r.sel_b[15:12];
endmodule

/* verilog/tiosel_pkg.sv */
// Package with constants and types for the timer I/O mode selector
package tiosel_pkg;
  localparam int          FIELD_W          = 4;
  localparam int          HI_FIELD_LSB     = 12;
  localparam int          LO_FIELD_LSB     = 8;
  localparam int          SEL_REG_W        = 16;
  localparam int          FUNC_SEL_W       = 3;
  localparam int          EGS_W            = 2;
  localparam int          NUM_PAIRS        = 4;
  localparam logic [15:0] SEL_RESET        = 16'h0000;
  localparam logic [2:0]  FUNC_SEL_RESET   = 3'h0;
  localparam logic [1:0]  EGS_UNUSED       = 2'h0;
  localparam logic [1:0]  EGS_RESET        = 2'h0;
  localparam logic [3:0]  MODE_MAX         = 4'h8;
  // Wishbone register offsets (byte addresses)
  localparam logic [3:0]  ADR_SEL_4567     = 4'h0;
  localparam logic [3:0]  ADR_SEL_89AB     = 4'h4;
  localparam logic [3:0]  ADR_CTRL         = 4'h8;
  localparam logic [3:0]  ADR_STATUS       = 4'hc;
  localparam logic [31:0] CTRL_RESET       = 32'h0000_0000;
  localparam logic [31:0] STATUS_RESET     = 32'h0000_0000;

  typedef enum logic [3:0] {
    TIOSEL_MODE_STD        = 4'h0,
    TIOSEL_MODE_FULL       = 4'h1,
    TIOSEL_MODE_SHR_EXT    = 4'h2,
    TIOSEL_MODE_SHR_CH     = 4'h3,
    TIOSEL_MODE_STARTSTOP  = 4'h4,
    TIOSEL_MODE_SW_SIM     = 4'h5,
    TIOSEL_MODE_SW_STSP    = 4'h6,
    TIOSEL_MODE_START      = 4'h7,
    TIOSEL_MODE_SHR_CH_STSP = 4'h8
  } tiosel_mode_t;

  typedef enum logic [1:0] {
    TIOSEL_ST_IDLE  = 2'b00,
    TIOSEL_ST_STOP  = 2'b01,
    TIOSEL_ST_WRITE = 2'b11,
    TIOSEL_ST_RUN   = 2'b10
  } tiosel_state_t;
endpackage

/* verilog/tiosel_if.sv */
// Interface between the selector and its controller
`timescale 1ns/10ps
interface tiosel_if;
  logic        sel_we;
  logic        sel_addr;
  logic [15:0] sel_wdata;
  logic [15:0] sel_rdata_a;
  logic [15:0] sel_rdata_b;
  logic [2:0]  timer_function_select;
  logic [1:0]  trigger_edge_select_ch9;
  logic        write_refused;
  logic        bad_code;
  logic        full_trig_conflict;
  modport device (
    input  sel_we, sel_addr, sel_wdata, timer_function_select, trigger_edge_select_ch9,
    output sel_rdata_a, sel_rdata_b, write_refused, bad_code, full_trig_conflict
  );
  modport host (
    output sel_we, sel_addr, sel_wdata, timer_function_select, trigger_edge_select_ch9,
    input  sel_rdata_a, sel_rdata_b, write_refused, bad_code, full_trig_conflict
  );
endinterface

/* verilog/tiosel_route.sv */
// Cascade routing for one channel pair
`timescale 1ns/10ps
module tiosel_route (
  // Clock and reset
  input  wire logic       clk_i,
  input  wire logic       rst_i,
  // Mode and cascade
  input  wire logic [3:0] mode_i,
  input  wire logic       cascade_in_i,
  input  wire logic       own_trig_i,
  output logic            trig_o,
  output logic            cascade_out_o
);
  typedef struct packed {
    logic trig;
    logic casc_out;
  } tiosel_route_t;
  tiosel_route_t r;
  tiosel_route_t next_r;

  always_comb begin
    next_r = r;
    case (mode_i)
      4'h3,
      4'h8: begin
        next_r.trig     = cascade_in_i; // [RULE11]
        next_r.casc_out = cascade_in_i;
      end
      default: begin
        next_r.trig     = own_trig_i;
        next_r.casc_out = own_trig_i;
      end
    endcase
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      r <= '0;
    end else begin
      r <= next_r;
    end
  end

  assign trig_o        = r.trig;
  assign cascade_out_o = r.casc_out;
endmodule

/* verilog/tiosel_host.sv */
// Wishbone controller driving the selector registers
`timescale 1ns/10ps
module tiosel_host (
  // Clock and reset
  input  wire logic        clk_i,
  input  wire logic        rst_i,
  // Wishbone slave
  input  wire logic        wb_cyc_i,
  input  wire logic        wb_stb_i,
  input  wire logic        wb_we_i,
  input  wire logic [3:0]  wb_adr_i,
  input  wire logic [3:0]  wb_sel_i,
  input  wire logic [31:0] wb_dat_i,
  output logic [31:0]      wb_dat_o,
  output logic             wb_ack_o,
  // Link to the selector
  tiosel_if.host           lnk
);
  typedef struct packed {
    logic [31:0] dat;
    logic        ack;
    logic        we;
    logic        addr;
    logic [15:0] wdata;
    logic [2:0]  func;
    logic [1:0]  egs;
    logic        refused;
  } tiosel_host_t;
  tiosel_host_t r;
  tiosel_host_t next_r;

  always_comb begin
    next_r     = r;
    next_r.ack = 1'b0;
    next_r.we  = 1'b0;
    if (lnk.write_refused) begin
      next_r.refused = 1'b1;
    end
    if (wb_cyc_i && wb_stb_i && !r.ack) begin
      next_r.ack = 1'b1;
      next_r.dat = 32'h0000_0000;
      case (wb_adr_i)
        tiosel_pkg::ADR_SEL_4567: begin
          next_r.dat = {16'h0000, lnk.sel_rdata_a};
          if (wb_we_i && wb_sel_i[1]) begin
            next_r.we    = 1'b1; // [RULE1] [RULE2]
            next_r.addr  = 1'b0;
            next_r.wdata = wb_dat_i[15:0];
          end
        end
        tiosel_pkg::ADR_SEL_89AB: begin
          next_r.dat = {16'h0000, lnk.sel_rdata_b};
          if (wb_we_i && wb_sel_i[1]) begin
            next_r.we    = 1'b1; // [RULE3] [RULE4]
            next_r.addr  = 1'b1;
            next_r.wdata = wb_dat_i[15:0];
          end
        end
        tiosel_pkg::ADR_CTRL: begin
          next_r.dat = {27'h0, r.egs, r.func};
          if (wb_we_i && wb_sel_i[0]) begin
            next_r.func = wb_dat_i[2:0]; // [RULE7]
            next_r.egs = wb_dat_i[4:3]; // [RULE9]
          end
        end
        tiosel_pkg::ADR_STATUS: begin
          next_r.dat = {29'h0, lnk.full_trig_conflict, lnk.bad_code, r.refused}; // [RULE8]
          if (wb_we_i && wb_sel_i[0] && wb_dat_i[0] && !lnk.write_refused) begin
            next_r.refused = 1'b0;
          end
        end
        default: begin
          next_r.dat = 32'h0000_0000;
        end
      endcase
    end
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      r <= '0;
    end else begin
      r <= next_r;
    end
  end

  assign wb_dat_o                    = r.dat;
  assign wb_ack_o                    = r.ack;
  assign lnk.sel_we                  = r.we;
  assign lnk.sel_addr                = r.addr;
  assign lnk.sel_wdata               = r.wdata;
  assign lnk.timer_function_select   = r.func;
  assign lnk.trigger_edge_select_ch9 = r.egs;
endmodule

/* verif/tiosel_asserts.sv */
// Checker on the link between controller and selector
`timescale 1ns/10ps
module tiosel_asserts (
  // Clock and reset
  input wire logic        clk_i,
  input wire logic        rst_i,
  // Link signals
  input wire logic        sel_we,
  input wire logic        sel_addr,
  input wire logic [15:0] sel_wdata,
  input wire logic [15:0] sel_rdata_a,
  input wire logic [15:0] sel_rdata_b,
  input wire logic [2:0]  timer_function_select,
  input wire logic [1:0]  trigger_edge_select_ch9,
  input wire logic        write_refused,
  input wire logic        bad_code,
  input wire logic        full_trig_conflict
);
  logic legal;
  logic conf;
  assign legal = sel_wdata[15:12] <= 4'h8 && sel_wdata[11:8] <= 4'h8;
  assign conf  = sel_rdata_b[11:8] == 4'h1 && trigger_edge_select_ch9 != 2'h0;
  default clocking cb @(posedge clk_i); endclocking
  default disable iff (rst_i);
  chk_write_a_lands: assert property (sel_we && !sel_addr && legal && timer_function_select == 3'h0
    |=> sel_rdata_a == {$past(sel_wdata[15:8]), 8'h00}) else $error("first register write lost");
  chk_write_b_lands: assert property (sel_we && sel_addr && legal && timer_function_select == 3'h0
    |=> sel_rdata_b == {$past(sel_wdata[15:8]), 8'h00}) else $error("second register write lost");
  chk_refuse_busy: assert property (sel_we && timer_function_select != 3'h0
    |=> write_refused && $stable(sel_rdata_a) && $stable(sel_rdata_b)) else $error("busy write taken");
  chk_refuse_code: assert property (sel_we && !legal
    |=> write_refused && $stable(sel_rdata_a) && $stable(sel_rdata_b)) else $error("bad code taken");
  chk_legal_accepted: assert property (sel_we && legal && timer_function_select == 3'h0
    |=> !write_refused) else $error("legal write refused");
  chk_reset_zero: assert property (disable iff (1'b0) rst_i
    |=> sel_rdata_a == 16'h0000 && sel_rdata_b == 16'h0000) else $error("fields not cleared");
  chk_hold_idle: assert property (!sel_we |=> $stable(sel_rdata_a) && $stable(sel_rdata_b))
    else $error("fields changed without write");
  chk_refuse_cause: assert property (write_refused |-> $past(sel_we))
    else $error("refusal without write");
  chk_no_bad_code: assert property (!bad_code) else $error("prohibited code stored");
  chk_conflict_set: assert property (conf [*2] |-> full_trig_conflict)
    else $error("full mode trigger conflict missed");
  chk_conflict_clear: assert property (!conf [*2] |-> !full_trig_conflict)
    else $error("false trigger conflict");
  cov_write: cover property (sel_we && legal && timer_function_select == 3'h0);
  cov_busy: cover property (sel_we && timer_function_select != 3'h0);
  cov_conf: cover property (full_trig_conflict);
endmodule

/* verif/tiosel_bench.sv */
// Testbench joining controller and selector
`timescale 1ns/10ps
module tiosel_bench;
  logic        clk_i = 1'b0;
  logic        rst_i = 1'b1;
  logic        wb_cyc_i = 1'b0, wb_stb_i = 1'b0, wb_we_i = 1'b0, wb_ack_o, cascade_in_i = 1'b0;
  logic [3:0]  wb_adr_i = 4'h0, wb_sel_i = 4'hf, pair_trig_i = 4'h0, pair_trig_o;
  logic [31:0] wb_dat_i = 32'h0, wb_dat_o, rq;
  logic [3:0]  m45, m67, m89, mab, wsel = 4'hf;
  logic        cascade_out;
  int          err_total = 0, total_checks = 0;
  always #5 clk_i = ~clk_i;
  tiosel_if lnk();
  tiosel_host u_tiosel_host (.clk_i, .rst_i, .wb_cyc_i, .wb_stb_i, .wb_we_i, .wb_adr_i,
    .wb_sel_i, .wb_dat_i, .wb_dat_o, .wb_ack_o, .lnk(lnk.host));
  tiosel_dev u_tiosel_dev (.clk_i, .rst_i, .lnk(lnk.device), .cascade_in_i, .pair_trig_i,
    .pair_trig_o, .cascade_out_o(cascade_out), .pair_four_five_mode_o(m45), .pair_six_seven_mode_o(m67),
    .pair_eight_nine_mode_o(m89), .pair_ten_eleven_mode_o(mab));
  tiosel_asserts u_tiosel_asserts (.clk_i, .rst_i, .sel_we(lnk.sel_we), .sel_addr(lnk.sel_addr),
    .sel_wdata(lnk.sel_wdata), .sel_rdata_a(lnk.sel_rdata_a), .sel_rdata_b(lnk.sel_rdata_b),
    .timer_function_select(lnk.timer_function_select), .write_refused(lnk.write_refused),
    .trigger_edge_select_ch9(lnk.trigger_edge_select_ch9), .bad_code(lnk.bad_code),
    .full_trig_conflict(lnk.full_trig_conflict));
  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    total_checks++;
    if (seen !== exp) begin
      err_total++;
      $display("wrong value at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask
  task automatic tally_and_finish;
    if (err_total == 0 && total_checks > 0) $display("RESULT: PASS");
    else $display("RESULT: FAIL");
    $finish;
  endtask
  task automatic wb(input logic w, input logic [3:0] a, input logic [31:0] d);
    int n;
    n = 0;
    @(posedge clk_i);
    wb_cyc_i <= 1'b1;
    wb_stb_i <= 1'b1;
    wb_we_i  <= w;
    wb_adr_i <= a;
    wb_sel_i <= wsel;
    wb_dat_i <= d;
    do begin
      @(posedge clk_i);
      n++;
    end while (wb_ack_o !== 1'b1 && n < 50);
    rq = wb_dat_o;
    wb_cyc_i <= 1'b0;
    wb_stb_i <= 1'b0;
    wb_we_i  <= 1'b0;
    if (n >= 50) begin
      err_total++;
      tally_and_finish();
    end
  endtask
  task automatic t_reset;
    wb(1'b0, 4'h0, 32'h0);
    check(rq, 32'h0);
    wb(1'b0, 4'h4, 32'h0);
    check(rq, 32'h0);
    wb(1'b0, 4'h2, 32'h0);
    check(rq, 32'h0);
    check({m45, m67, m89, mab}, 32'h0);
  endtask
  task automatic t_codes;
    logic [3:0] c, k;
    for (int i = 0; i < 9; i++) begin
      c = i[3:0];
      k = 4'h8 - c;
      wb(1'b1, 4'h0, {16'h0, c, k, 8'h00});
      wb(1'b1, 4'h4, {16'h0, k, c, 8'h00});
      wb(1'b0, 4'h0, 32'h0);
      check(rq, {16'h0, c, k, 8'h00});
      wb(1'b0, 4'h4, 32'h0);
      check(rq, {16'h0, k, c, 8'h00});
      check(m67, c);
      check(m45, k);
      check(mab, k);
      check(m89, c);
    end
  endtask
  task automatic t_bad;
    for (int i = 9; i < 16; i++) begin
      wb(1'b1, 4'h0, {16'h0, i[3:0], 12'h000});
      wb(1'b0, 4'h0, 32'h0);
      check(rq, 32'h8000);
      wb(1'b0, 4'hc, 32'h0);
      check(rq[1:0], 2'b01);
      wb(1'b1, 4'hc, 32'h1);
    end
  endtask
  task automatic t_busy;
    wb(1'b1, 4'h8, 32'h1);
    wb(1'b1, 4'h4, 32'h0100);
    wb(1'b0, 4'h4, 32'h0);
    check(rq, 32'h0800);
    wb(1'b0, 4'hc, 32'h0);
    check(rq[0], 1'b1);
    wb(1'b1, 4'hc, 32'h1);
    wb(1'b0, 4'hc, 32'h0);
    check(rq[0], 1'b0);
    wb(1'b1, 4'h8, 32'h0);
    wb(1'b1, 4'h4, 32'h0100);
    wb(1'b0, 4'h4, 32'h0);
    check(rq, 32'h0100);
    wb(1'b1, 4'h8, 32'h08);
    wb(1'b0, 4'hc, 32'h0);
    check(rq[2], 1'b1);
    wb(1'b1, 4'h8, 32'h0);
    wb(1'b0, 4'hc, 32'h0);
    check(rq[2], 1'b0);
  endtask
  task automatic t_casc;
    wb(1'b1, 4'h0, 32'h0300);
    cascade_in_i <= 1'b1;
    repeat (4) @(posedge clk_i);
    check(pair_trig_o[0], 1'b1);
    cascade_in_i <= 1'b0;
    repeat (4) @(posedge clk_i);
    check(pair_trig_o[0], 1'b0);
  endtask
  task automatic t_route;
    wb(1'b1, 4'h0, 32'h8300);
    wb(1'b1, 4'h4, 32'h3300);
    cascade_in_i <= 1'b1;
    repeat (6) @(posedge clk_i);
    check(pair_trig_o, 4'hf);
    check(cascade_out, 1'b1);
    cascade_in_i <= 1'b0;
    repeat (6) @(posedge clk_i);
    check(pair_trig_o, 4'h0);
    check(cascade_out, 1'b0);
    wb(1'b1, 4'h0, 32'h0000);
    wb(1'b1, 4'h4, 32'h0000);
    cascade_in_i <= 1'b1;
    pair_trig_i  <= 4'ha;
    repeat (3) @(posedge clk_i);
    check(pair_trig_o, 4'ha);
    check(cascade_out, 1'b1);
    cascade_in_i <= 1'b0;
    pair_trig_i  <= 4'h0;
    wsel = 4'h1;
    wb(1'b1, 4'h0, 32'h3300);
    wsel = 4'hf;
    wb(1'b0, 4'h0, 32'h0);
    check(rq, 32'h0);
  endtask
  task automatic t_rerun;
    wb(1'b1, 4'h0, 32'h8800);
    wb(1'b1, 4'h8, 32'h0a);
    rst_i <= 1'b1;
    repeat (2) @(posedge clk_i);
    rst_i <= 1'b0;
    wb(1'b0, 4'h0, 32'h0);
    check(rq, 32'h0);
    wb(1'b0, 4'h8, 32'h0);
    check(rq, 32'h0);
    check({m45, m67, m89, mab}, 32'h0);
  endtask
  initial begin
    repeat (2) @(posedge clk_i);
    rst_i <= 1'b0;
    t_reset();
    t_codes();
    t_bad();
    t_busy();
    t_casc();
    t_route();
    t_rerun();
    tally_and_finish();
  end
endmodule
